//--- verilog/pdsau_pkg.sv
package pdsau_pkg;

  // Widths of the two address spaces and their words
  localparam int DATA_W = 16;
  localparam int PROG_W = 24;
  localparam int PADDR_W = 24;
  localparam int PC_W = 23;
  localparam int PAGE_W = 8;
  localparam int PSV_LOW_W = 15;
  localparam int PSV_HIT_BIT = 15;
  localparam int CFG_SPACE_BIT = 7;
  localparam int BYTE_SEL_BIT = 0;

  // Program counter steps two per program word
  localparam logic [PC_W-1:0] PC_STEP = 23'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 23'h000000;

  // Fixed X/Y boundary; software has no hold on it
  localparam logic [15:0] Y_FIRST = 16'h0800;
  localparam logic [15:0] Y_LAST = 16'h0fff;
  localparam logic [15:0] RAM_LAST_DEF = 16'h0fff;

  // Extra cycles that a visibility access costs
  localparam logic [1:0] XTRA_NONE = 2'h0;
  localparam logic [1:0] XTRA_ONE = 2'h1;
  localparam logic [1:0] XTRA_TWO = 2'h2;

  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [2:0] {
    OP_DATA_READ = 3'h0,
    OP_DATA_WRITE = 3'h1,
    OP_MAC_READ = 3'h2,
    OP_TABLE_READ_LOW = 3'h3,
    OP_TABLE_READ_HIGH = 3'h4,
    OP_TABLE_WRITE_LOW = 3'h5,
    OP_TABLE_WRITE_HIGH = 3'h6
  } pdsau_op_type;

  typedef enum logic [1:0] {
    IC_OTHER = 2'h0,
    IC_MAC_PREFETCH = 2'h1,
    IC_MOVE = 2'h2,
    IC_DOUBLE_MOVE = 2'h3
  } pdsau_iclass_type;

  typedef enum logic [1:0] {
    PTR_X_A = 2'h0,
    PTR_X_B = 2'h1,
    PTR_Y_A = 2'h2,
    PTR_Y_B = 2'h3
  } pdsau_ptr_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_HOLD = 4'b0100,
    ST_WAIT = 4'b1000
  } pdsau_state_type;

  typedef struct packed {
    logic valid;
    pdsau_op_type op;
    pdsau_iclass_type iclass;
    logic byteMode;
    logic [15:0] ea;
    pdsau_ptr_type xPtr;
    logic [15:0] yEa;
    pdsau_ptr_type yPtr;
    logic [15:0] xStep;
    logic [15:0] yStep;
    logic [15:0] wrData;
    logic inRepeat;
    logic repFirst;
    logic repLast;
    logic repIntExit;
    logic repReentry;
  } pdsau_req_type;

  typedef struct packed {
    logic modEn;
    logic [15:0] start;
    logic [15:0] last;
    logic bitRevEn;
    logic [15:0] bitRevMod;
  } pdsau_mod_type;

  typedef struct packed {
    logic valid;
    logic [15:0] xData;
    logic [15:0] yData;
  } pdsau_rsp_type;

endpackage

//--- verilog/pdsau_agu.sv
`timescale 1ns/1ps
// Pointer post-modify: plain add, modulo wrap or bit-reversed carry
module pdsau_agu
  import pdsau_pkg::*;
(
  input wire logic [15:0] ptr,
  input wire logic [15:0] step,
  input wire pdsau_mod_type mode,
  input wire logic revAllow,
  output logic [15:0] nextPtr
);

  logic [15:0] sum;
  logic [15:0] revPtr;
  logic [15:0] revMod;
  logic [15:0] revSum;
  logic [15:0] revOut;

  ////////////////////////////////////////////////////////////////////////
  // Bit mirror of pointer, modifier and the mirrored sum
  for (genvar i = 0; i < 16; i++) begin : g_rev
    assign revPtr[i] = ptr[15-i];
    assign revMod[i] = mode.bitRevMod[15-i];
    assign revOut[i] = revSum[15-i];
  end

  assign revSum = revPtr + revMod;
  assign sum = ptr + step;

  ////////////////////////////////////////////////////////////////////////
  // Bit reversal beats modulo when both are asked for
  always_comb begin
    nextPtr = sum;
    if (mode.bitRevEn && revAllow) begin
      nextPtr = revOut;
    end else if (mode.modEn) begin
      // Wrap only on the buffer edge in the direction of travel
      if (!step[15] && ptr == mode.last) begin
        nextPtr = mode.start;
      end else if (step[15] && ptr == mode.start) begin
        nextPtr = mode.last;
      end
    end
  end

endmodule

//--- verilog/pdsau_core.sv
`timescale 1ns/1ps
// Functional notes
// - Table read low, word: program bits 15..0 pass unchanged.
// - Table read low, byte: select picks program bits 7..0 or 15..8.
// - Table read high, word: program bits 23..16 in low byte, top zero.
// - Table read high, byte: bits 23..16 when select clear, else zero.
// - Only table high operations reach the top program byte.
// - Program counter steps two per program word.
// - Visibility applies only when address top bit and enable both set.
// - Visibility address: page register above low 15 address bits.
// - Visibility reads return only the low 16 program bits.
// - Visibility mapping is off during table reads and writes.
// - Outside repeat: one extra cycle for prefetch/moves, else two.
// - In repeat: two extra on edge iterations, else none.
// - MAC reads exclude Y from X; others see whole 64K as X.
// - MAC reads use X pointers for X, Y pointers for Y, together.
// - Y bus never writes; data writes outside the visibility window go over X write bus.
// - Y space serves MAC prefetch only, with modulo addressing.
// - X supports modulo always, bit reversal only for writes.
// - The X/Y boundary is a fixed constant.
// - Unimplemented or wrong-space MAC reads return zero.
// - Data addresses are 16-bit byte addresses.
// - Table page bit 7 selects configuration space.
module pdsau_core
  import pdsau_pkg::*;
#(
  parameter logic [15:0] RAM_LAST = RAM_LAST_DEF
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire pdsau_req_type req,
  output logic ready,
  input wire logic visibilityEnable,
  input wire logic [PAGE_W-1:0] visibilityPageReg,
  input wire logic [PAGE_W-1:0] tablePageReg,
  input wire pdsau_mod_type xMod,
  input wire pdsau_mod_type yMod,
  input wire logic pcAdvance,
  input wire logic pcLoad,
  input wire logic [PC_W-1:0] pcLoadValue,
  output logic [PC_W-1:0] pc,
  output logic [PADDR_W-1:0] progAddr,
  output logic progRd,
  output logic configSpace,
  input wire logic [PROG_W-1:0] progData,
  output logic [15:0] xRdAddr,
  output logic xRdStrobe,
  input wire logic [15:0] xRdData,
  output logic [15:0] yRdAddr,
  output logic yRdStrobe,
  input wire logic [15:0] yRdData,
  output logic [15:0] xWrAddr,
  output logic xWrStrobe,
  output logic xWrByte,
  output logic [15:0] xWrData,
  output pdsau_rsp_type rsp,
  output logic [15:0] xPtrNext,
  output logic [15:0] yPtrNext
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic inYSpace(input logic [15:0] a);
    inYSpace = (a >= Y_FIRST) && (a <= Y_LAST);
  endfunction

  // Byte reads land in the low byte; the top byte reads zero
  function automatic logic [15:0] pickByte(input logic [15:0] w,
                                           input logic sel,
                                           input logic byteMode);
    if (!byteMode) begin
      pickByte = w;
    end else if (sel) begin
      pickByte = {ZERO_BYTE, w[15:8]};
    end else begin
      pickByte = {ZERO_BYTE, w[7:0]};
    end
  endfunction

  // Table steering; the top program byte is reachable only here
  function automatic logic [15:0] tableSteer(input logic [23:0] p,
                                             input logic high,
                                             input logic sel,
                                             input logic byteMode);
    if (!high) begin
      tableSteer = pickByte(p[15:0], sel, byteMode);
    end else if (byteMode && sel) begin
      tableSteer = ZERO_WORD;
    end else begin
      tableSteer = {ZERO_BYTE, p[23:16]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Request decode
  logic take;
  logic isTable;
  logic isTableRead;
  logic isWrite;
  logic isMac;
  logic psvHit;
  logic xZero;
  logic yZero;
  logic xPtrOk;
  logic yPtrOk;
  logic [1:0] extra;
  logic [15:0] aguXNext;
  logic [15:0] aguYNext;

  assign take = ready && req.valid;

  always_comb begin
    isTable = (req.op == OP_TABLE_READ_LOW) ||
              (req.op == OP_TABLE_READ_HIGH) ||
              (req.op == OP_TABLE_WRITE_LOW) ||
              (req.op == OP_TABLE_WRITE_HIGH);
    isTableRead = (req.op == OP_TABLE_READ_LOW) ||
                  (req.op == OP_TABLE_READ_HIGH);
    isWrite = (req.op == OP_DATA_WRITE);
    isMac = (req.op == OP_MAC_READ);
    // Table operations bypass the visibility window entirely
    psvHit = !isTable && visibilityEnable &&
             req.ea[PSV_HIT_BIT];
    xPtrOk = (req.xPtr == PTR_X_A) || (req.xPtr == PTR_X_B);
    yPtrOk = (req.yPtr == PTR_Y_A) || (req.yPtr == PTR_Y_B);
    // Non-MAC reads see Y as part of X; MAC X reads do not
    xZero = !psvHit && (req.ea > RAM_LAST);
    if (isMac) begin
      xZero = xZero || !xPtrOk ||
              (!psvHit && inYSpace(req.ea));
    end
    yZero = !yPtrOk || !inYSpace(req.yEa) ||
            (req.yEa > RAM_LAST);
    // Visibility timing penalty
    extra = XTRA_NONE;
    if (psvHit && !req.inRepeat) begin
      if (req.iclass == IC_OTHER) begin
        extra = XTRA_TWO;
      end else begin
        extra = XTRA_ONE;
      end
    end else if (psvHit) begin
      if (req.repFirst || req.repLast || req.repIntExit ||
          req.repReentry) begin
        extra = XTRA_TWO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pointer post-modify; Y never bit-reverses, X only on writes
  pdsau_agu u_agu_x (
    .ptr(req.ea),
    .step(req.xStep),
    .mode(xMod),
    .revAllow(isWrite),
    .nextPtr(aguXNext)
  );

  pdsau_agu u_agu_y (
    .ptr(req.yEa),
    .step(req.yStep),
    .mode(yMod),
    .revAllow(1'b0),
    .nextPtr(aguYNext)
  );

  ////////////////////////////////////////////////////////////////////////
  // Program counter
  logic [PC_W-1:0] next_pc;

  always_comb begin
    next_pc = pc;
    if (pcLoad) begin
      next_pc = {pcLoadValue[PC_W-1:1], 1'b0};
    end else if (pcAdvance) begin
      next_pc = pc + PC_STEP;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc <= PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Access sequencer: issue, hold memory answer, pay extra cycles
  pdsau_state_type state, next_state;
  pdsau_op_type ctxOp, next_ctxOp;
  logic ctxByte, next_ctxByte;
  logic ctxSel, next_ctxSel;
  logic ctxPsv, next_ctxPsv;
  logic ctxXZero, next_ctxXZero;
  logic ctxYZero, next_ctxYZero;
  logic [1:0] extraCnt, next_extraCnt;
  logic next_ready;
  logic [PADDR_W-1:0] next_progAddr;
  logic next_progRd;
  logic next_configSpace;
  logic [15:0] next_xRdAddr;
  logic next_xRdStrobe;
  logic [15:0] next_yRdAddr;
  logic next_yRdStrobe;
  logic [15:0] next_xWrAddr;
  logic next_xWrStrobe;
  logic next_xWrByte;
  logic [15:0] next_xWrData;
  pdsau_rsp_type next_rsp;
  logic [15:0] next_xPtrNext;
  logic [15:0] next_yPtrNext;
  logic [15:0] holdX;

  // Read result from the memory answer of the held request
  always_comb begin
    holdX = ZERO_WORD;
    if (ctxXZero) begin
      holdX = ZERO_WORD;
    end else if (ctxOp == OP_TABLE_READ_LOW) begin
      holdX = tableSteer(progData, 1'b0, ctxSel, ctxByte);
    end else if (ctxOp == OP_TABLE_READ_HIGH) begin
      holdX = tableSteer(progData, 1'b1, ctxSel, ctxByte);
    end else if (ctxOp == OP_DATA_READ || ctxOp == OP_MAC_READ) begin
      if (ctxPsv) begin
        holdX = pickByte(progData[15:0], ctxSel, ctxByte);
      end else begin
        holdX = pickByte(xRdData, ctxSel, ctxByte);
      end
    end
  end

  always_comb begin
    next_state = state;
    next_ctxOp = ctxOp;
    next_ctxByte = ctxByte;
    next_ctxSel = ctxSel;
    next_ctxPsv = ctxPsv;
    next_ctxXZero = ctxXZero;
    next_ctxYZero = ctxYZero;
    next_extraCnt = extraCnt;
    next_progAddr = progAddr;
    next_progRd = 1'b0;
    next_configSpace = configSpace;
    next_xRdAddr = xRdAddr;
    next_xRdStrobe = 1'b0;
    next_yRdAddr = yRdAddr;
    next_yRdStrobe = 1'b0;
    next_xWrAddr = xWrAddr;
    next_xWrStrobe = 1'b0;
    next_xWrByte = xWrByte;
    next_xWrData = xWrData;
    next_rsp = rsp;
    next_rsp.valid = 1'b0;
    next_xPtrNext = xPtrNext;
    next_yPtrNext = yPtrNext;
    unique case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = ST_FETCH;
          next_ctxOp = req.op;
          next_ctxByte = req.byteMode;
          next_ctxSel = req.ea[BYTE_SEL_BIT];
          next_ctxPsv = psvHit;
          next_ctxXZero = xZero && !isTable;
          next_ctxYZero = !isMac || yZero;
          next_extraCnt = extra;
          next_xPtrNext = aguXNext;
          next_yPtrNext = isMac ? aguYNext : yPtrNext;
          if (isTable) begin
            // Configuration space follows the table page top bit
            next_progAddr = {tablePageReg, req.ea};
            next_configSpace = tablePageReg[CFG_SPACE_BIT];
            next_progRd = isTableRead;
          end else if (psvHit) begin
            next_progAddr = {1'b0, visibilityPageReg,
                             req.ea[PSV_LOW_W-1:0]};
            next_configSpace = 1'b0;
            // Program space is not writable through the window
            next_progRd = !isWrite;
          end else if (isWrite) begin
            next_xWrAddr = req.ea;
            next_xWrStrobe = 1'b1;
            next_xWrByte = req.byteMode;
            next_xWrData = req.wrData;
          end else if (!xZero) begin
            next_xRdAddr = req.ea;
            next_xRdStrobe = 1'b1;
          end
          if (isMac && !yZero) begin
            next_yRdAddr = req.yEa;
            next_yRdStrobe = 1'b1;
          end
        end
      end
      ST_FETCH: begin
        next_state = ST_HOLD;
      end
      ST_HOLD: begin
        next_rsp.xData = holdX;
        next_rsp.yData = ctxYZero ? ZERO_WORD : yRdData;
        if (extraCnt == XTRA_NONE) begin
          next_rsp.valid = 1'b1;
          next_state = ST_IDLE;
        end else begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Each pass here is one extra cycle charged to the access
        next_extraCnt = extraCnt - XTRA_ONE;
        if (extraCnt == XTRA_ONE) begin
          next_rsp.valid = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_ready = (next_state == ST_IDLE);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      ready <= 1'b1;
      ctxOp <= OP_DATA_READ;
      ctxByte <= 1'b0;
      ctxSel <= 1'b0;
      ctxPsv <= 1'b0;
      ctxXZero <= 1'b0;
      ctxYZero <= 1'b0;
      extraCnt <= XTRA_NONE;
      progAddr <= '0;
      progRd <= 1'b0;
      configSpace <= 1'b0;
      xRdAddr <= ZERO_WORD;
      xRdStrobe <= 1'b0;
      yRdAddr <= ZERO_WORD;
      yRdStrobe <= 1'b0;
      xWrAddr <= ZERO_WORD;
      xWrStrobe <= 1'b0;
      xWrByte <= 1'b0;
      xWrData <= ZERO_WORD;
      rsp <= '0;
      xPtrNext <= ZERO_WORD;
      yPtrNext <= ZERO_WORD;
    end else begin
      state <= next_state;
      ready <= next_ready;
      ctxOp <= next_ctxOp;
      ctxByte <= next_ctxByte;
      ctxSel <= next_ctxSel;
      ctxPsv <= next_ctxPsv;
      ctxXZero <= next_ctxXZero;
      ctxYZero <= next_ctxYZero;
      extraCnt <= next_extraCnt;
      progAddr <= next_progAddr;
      progRd <= next_progRd;
      configSpace <= next_configSpace;
      xRdAddr <= next_xRdAddr;
      xRdStrobe <= next_xRdStrobe;
      yRdAddr <= next_yRdAddr;
      yRdStrobe <= next_yRdStrobe;
      xWrAddr <= next_xWrAddr;
      xWrStrobe <= next_xWrStrobe;
      xWrByte <= next_xWrByte;
      xWrData <= next_xWrData;
      rsp <= next_rsp;
      xPtrNext <= next_xPtrNext;
      yPtrNext <= next_yPtrNext;
    end
  end

endmodule

//--- bench/pdsau_core_chk.sv
`timescale 1ns/1ps
// Port-level watcher for steering, latency and address building
module pdsau_core_chk
  import pdsau_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire pdsau_req_type req,
  input wire logic ready,
  input wire logic visibilityEnable,
  input wire logic [PAGE_W-1:0] visibilityPageReg,
  input wire logic [PAGE_W-1:0] tablePageReg,
  input wire pdsau_mod_type xMod,
  input wire pdsau_mod_type yMod,
  input wire logic pcAdvance,
  input wire logic pcLoad,
  input wire logic [PC_W-1:0] pcLoadValue,
  input wire logic [PC_W-1:0] pc,
  input wire logic [PADDR_W-1:0] progAddr,
  input wire logic progRd,
  input wire logic configSpace,
  input wire logic [PROG_W-1:0] progData,
  input wire logic [15:0] xRdAddr,
  input wire logic xRdStrobe,
  input wire logic [15:0] xRdData,
  input wire logic [15:0] yRdAddr,
  input wire logic yRdStrobe,
  input wire logic [15:0] yRdData,
  input wire logic [15:0] xWrAddr,
  input wire logic xWrStrobe,
  input wire logic xWrByte,
  input wire logic [15:0] xWrData,
  input wire pdsau_rsp_type rsp,
  input wire logic [15:0] xPtrNext,
  input wire logic [15:0] yPtrNext
);
  ////////////////////////////////////////////////////////////////////////////
  // Request kinds decoded at the taking edge
  logic take;
  logic visHit;
  logic visRd;
  logic macTake;
  logic repEdge;
  assign take = ready && req.valid;
  assign visHit = visibilityEnable && req.ea[15];
  assign visRd = take && req.op == OP_DATA_READ && visHit;
  assign macTake = take && req.op == OP_MAC_READ;
  assign repEdge = req.repFirst || req.repLast || req.repIntExit
    || req.repReentry;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  // Busy stretch then a single answer, one per extra-cycle count
  sequence ans0;
    (!ready && !rsp.valid) [*2] ##1 (ready && rsp.valid);
  endsequence
  sequence ans1;
    (!ready && !rsp.valid) [*3] ##1 (ready && rsp.valid);
  endsequence
  sequence ans2;
    (!ready && !rsp.valid) [*4] ##1 (ready && rsp.valid);
  endsequence
  sequence pcIdle2;
    !(pcAdvance || pcLoad) [*2];
  endsequence

  plain_latency_a: assert property (take && !visHit |-> ##1 ans0)
    else $error("plain access answer timing wrong");
  vis_other_a: assert property (visRd && !req.inRepeat
    && req.iclass == IC_OTHER |-> ##1 ans2)
    else $error("visibility read lacks two extra cycles");
  vis_short_a: assert property (visRd && !req.inRepeat
    && req.iclass != IC_OTHER |-> ##1 ans1)
    else $error("visibility move lacks one extra cycle");
  rep_middle_a: assert property (visRd && req.inRepeat && !repEdge
    |-> ##1 ans0)
    else $error("middle repeat iteration not single cycle");
  rep_edge_a: assert property (visRd && req.inRepeat && repEdge
    |-> ##1 ans2)
    else $error("edge repeat iteration lacks two cycles");
  vis_addr_a: assert property (visRd |=> progRd
    && progAddr == {1'b0, $past(visibilityPageReg), $past(req.ea[14:0])})
    else $error("visibility program address wrong");
  table_addr_a: assert property (take && (req.op == OP_TABLE_READ_LOW
    || req.op == OP_TABLE_READ_HIGH) |=> progRd
    && progAddr == {$past(tablePageReg), $past(req.ea)}
    && configSpace == $past(tablePageReg[CFG_SPACE_BIT]))
    else $error("table program address or space wrong");
  no_vis_a: assert property (take && req.op == OP_DATA_READ && !visHit
    |=> !progRd)
    else $error("program read without visibility");
  mac_dual_a: assert property (macTake && req.xPtr <= PTR_X_B
    && req.yPtr >= PTR_Y_A && req.ea < Y_FIRST && req.yEa >= Y_FIRST
    && req.yEa <= Y_LAST |=> xRdStrobe && yRdStrobe
    && yRdAddr == $past(req.yEa))
    else $error("dual read not issued together");
  y_wrong_ptr_a: assert property (macTake && req.yPtr <= PTR_X_B
    |=> !yRdStrobe ##2 rsp.valid && rsp.yData == ZERO_WORD)
    else $error("Y read by X pointer not zero");
  x_in_y_a: assert property (macTake && req.ea >= Y_FIRST
    && req.ea <= Y_LAST |=> !xRdStrobe ##2 rsp.xData == ZERO_WORD)
    else $error("MAC X read in Y region not zero");
  write_path_a: assert property (take && req.op == OP_DATA_WRITE && !visHit
    |=> xWrStrobe && xWrAddr == $past(req.ea)
    && xWrData == $past(req.wrData))
    else $error("write not carried on X write bus");
  write_drop_a: assert property (take && req.op == OP_DATA_WRITE && visHit
    |=> !xWrStrobe)
    else $error("write into visibility window not dropped");
  pc_step_a: assert property (pcIdle2 ##1 (pcAdvance && !pcLoad)
    ##1 pcIdle2 |=> pc == $past(pc, 3) + PC_STEP)
    else $error("program counter step not two");
endmodule

//--- bench/pdsau_mem_model.sv
`timescale 1ns/1ps
// Program memory and X/Y RAM answering in the cycle after each strobe
module pdsau_mem_model
  import pdsau_pkg::*;
(
  input wire logic clk,
  input wire logic [PADDR_W-1:0] progAddr,
  input wire logic progRd,
  input wire logic [15:0] xRdAddr,
  input wire logic xRdStrobe,
  input wire logic [15:0] yRdAddr,
  input wire logic yRdStrobe,
  output logic [PROG_W-1:0] progData,
  output logic [15:0] xRdData,
  output logic [15:0] yRdData
);
  ////////////////////////////////////////////////////////////////////////////
  // Content depends on the word address only; byte bit is ignored
  initial begin
    progData = 24'h000000;
    xRdData = 16'h0000;
    yRdData = 16'h0000;
  end

  // Data is good for one cycle; after that the lines invert so a late
  // sample cannot pass by luck
  always @(posedge clk) begin
    progData <= progRd ? {{progAddr[7:1], 1'b0} ^ 8'h96,
      {progAddr[15:1], 1'b0} ^ {progAddr[23:16], 8'h3c}} : ~progData;
    xRdData <= xRdStrobe ? {xRdAddr[15:1], 1'b0} ^ 16'h5555 : ~xRdData;
    yRdData <= yRdStrobe ? {yRdAddr[15:1], 1'b0} ^ 16'haaaa : ~yRdData;
  end
endmodule

//--- bench/pdsau_core_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the program and data space access unit
module pdsau_core_bench
  import pdsau_pkg::*;
;
  localparam logic [15:0] RAM_TOP = 16'h0fff;
  typedef struct packed {
    logic [2:0] op; logic [1:0] ic; logic bm; logic [15:0] ea;
    logic ven; logic [4:0] rep; logic [1:0] xp; logic [1:0] yp;
    logic [15:0] yEa; logic [15:0] xd; logic [15:0] yd; logic [1:0] ex;
  } pdsau_row_type;

  logic clk, sys_rst, ready, visibilityEnable, pcAdvance, pcLoad;
  logic progRd, configSpace, xRdStrobe, yRdStrobe, xWrStrobe, xWrByte;
  pdsau_req_type req;
  pdsau_mod_type xMod, yMod;
  pdsau_rsp_type rsp;
  logic [PAGE_W-1:0] visibilityPageReg, tablePageReg;
  logic [PC_W-1:0] pcLoadValue, pc;
  logic [PADDR_W-1:0] progAddr;
  logic [PROG_W-1:0] progData;
  logic [15:0] xRdAddr, xRdData, yRdAddr, yRdData, xWrAddr, xWrData;
  logic [15:0] xPtrNext, yPtrNext;
  int nMismatch, nCompared, cycles;
  pdsau_row_type rows[$];

  pdsau_core #(.RAM_LAST(RAM_TOP)) DUT (.*);
  pdsau_mem_model mem (.*);

  ////////////////////////////////////////////////////////////////////////////
  // Expected memory contents, written independently of the model
  function automatic logic [23:0] pw(input logic [23:0] a);
    return {{a[7:1], 1'b0} ^ 8'h96, {a[15:1], 1'b0} ^ {a[23:16], 8'h3c}};
  endfunction
  function automatic logic [15:0] xw(input logic [15:0] a);
    return {a[15:1], 1'b0} ^ 16'h5555;
  endfunction
  function automatic logic [15:0] bsel(input logic [15:0] w, input logic s);
    return s ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction

  // Fills the expected answer of a row from the current page settings
  function automatic pdsau_row_type fill(input pdsau_row_type r);
    logic [23:0] p;
    r.xd = 16'h0000;
    r.yd = 16'h0000;
    r.ex = 2'h0;
    if (r.op == 3'h3 || r.op == 3'h4) begin
      p = pw({tablePageReg, r.ea});
      if (r.op == 3'h3) r.xd = r.bm ? bsel(p[15:0], r.ea[0]) : p[15:0];
      else r.xd = (r.bm && r.ea[0]) ? 16'h0000 : {8'h00, p[23:16]};
    end else if (r.ven && r.ea[15]) begin
      p = pw({1'b0, visibilityPageReg, r.ea[14:0]});
      r.xd = r.bm ? bsel(p[15:0], r.ea[0]) : p[15:0];
      if (r.rep[4]) r.ex = (|r.rep[3:0]) ? 2'h2 : 2'h0;
      else r.ex = (r.ic == 2'h0) ? 2'h2 : 2'h1;
    end else if (r.op == 3'h2) begin
      if (r.xp < 2'h2 && r.ea < Y_FIRST) r.xd = xw(r.ea);
      if (r.yp > 2'h1 && r.yEa >= Y_FIRST && r.yEa <= Y_LAST)
        r.yd = {r.yEa[15:1], 1'b0} ^ 16'haaaa;
    end else if (r.ea <= RAM_TOP) begin
      r.xd = r.bm ? bsel(xw(r.ea), r.ea[0]) : xw(r.ea);
    end
    return r;
  endfunction

  task automatic add(input logic [2:0] op, input logic [1:0] ic,
      input logic bm, input logic [15:0] ea, input logic ven = 1'b0,
      input logic [4:0] rep = 5'h00, input logic [1:0] xp = 2'h0,
      input logic [1:0] yp = 2'h2, input logic [15:0] yEa = 16'h0000);
    rows.push_back({op, ic, bm, ea, ven, rep, xp, yp, yEa, 34'h0});
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    nCompared++;
    if (seen !== want) begin
      nMismatch++;
      $display("BAD at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One request: present it, count edges to the answer, compare
  task automatic run(input pdsau_row_type r);
    int t;
    t = 1;
    req <= {1'b1, r.op, r.ic, r.bm, r.ea, r.xp, r.yEa, r.yp, 32'h00020002,
      r.yEa, r.rep};
    visibilityEnable <= r.ven;
    @(posedge clk);
    req.valid <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      t++;
    end while (rsp.valid !== 1'b1 && t < 10);
    if (r.op != 3'h1 && r.op < 3'h5)
      check({rsp.xData, rsp.yData}, {r.xd, r.yd});
    check(t, 3 + r.ex);
    check(xPtrNext, r.ea + 2);
    @(posedge clk);
  endtask

  task automatic give_verdict();
    $display("Compared %0d, mismatched %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the run needs well under a thousand cycles
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      nMismatch++;
      give_verdict();
    end
  end

  // Main sequence: row table twice with other pages, then hand cases
  initial begin
    {sys_rst, req, xMod, yMod, visibilityEnable} = {1'b1, 197'h0};
    {pcAdvance, pcLoad, pcLoadValue, nMismatch, nCompared, cycles} = '0;
    tablePageReg = 8'h83;
    visibilityPageReg = 8'h12;
    add(3'h3, 2'h0, 1'b0, 16'h1234);
    add(3'h3, 2'h0, 1'b1, 16'h1234);
    add(3'h3, 2'h0, 1'b1, 16'h1235);
    add(3'h4, 2'h0, 1'b0, 16'h2220);
    add(3'h4, 2'h0, 1'b1, 16'h2220);
    add(3'h4, 2'h0, 1'b1, 16'h2221);
    add(3'h3, 2'h0, 1'b0, 16'h9000, 1'b1);
    add(3'h0, 2'h0, 1'b0, 16'h0100);
    add(3'h0, 2'h0, 1'b1, 16'h0101);
    add(3'h0, 2'h0, 1'b0, 16'h0900);
    add(3'h0, 2'h0, 1'b0, 16'h2000);
    add(3'h0, 2'h0, 1'b0, 16'h8006);
    for (int k = 0; k < 4; k++)
      add(3'h0, k[1:0], k[0], 16'h8006 + 16'(k * 2), 1'b1);
    for (int k = 0; k < 5; k++)
      add(3'h0, 2'h0, 1'b0, 16'h8010, 1'b1, 5'h10 | (5'h10 >> k));
    add(3'h2, 2'h1, 1'b0, 16'h0200, 1'b0, 5'h00, 2'h0, 2'h2, 16'h0810);
    add(3'h2, 2'h1, 1'b0, 16'h0204, 1'b0, 5'h00, 2'h1, 2'h3, 16'h0ffe);
    add(3'h2, 2'h1, 1'b0, 16'h0900, 1'b0, 5'h00, 2'h0, 2'h2, 16'h0800);
    add(3'h2, 2'h1, 1'b0, 16'h0200, 1'b0, 5'h00, 2'h2, 2'h0, 16'h0810);
    add(3'h2, 2'h1, 1'b0, 16'h0200, 1'b0, 5'h00, 2'h1, 2'h3, 16'h0200);
    add(3'h1, 2'h0, 1'b0, 16'h0300, 1'b0, 5'h00, 2'h0, 2'h2, 16'hbeef);
    add(3'h1, 2'h2, 1'b0, 16'h8004, 1'b1, 5'h00, 2'h0, 2'h2, 16'h1111);
    add(3'h5, 2'h0, 1'b0, 16'h0400);
    add(3'h6, 2'h0, 1'b0, 16'h0402);
    repeat (6) @(posedge clk);
    #1;
    check({ready, pc, rsp}, {1'b1, PC_RESET, 33'h0});
    @(posedge clk);
    sys_rst <= 1'b0;
    for (int pass = 0; pass < 2; pass++) begin
      foreach (rows[i]) begin
        rows[i] = fill(rows[i]);
        run(rows[i]);
      end
      tablePageReg <= 8'h05;
      visibilityPageReg <= 8'h7e;
      @(posedge clk);
    end
    // Load beats advance, low bit forced clear, then one advance
    pcLoadValue <= 23'h001235;
    {pcLoad, pcAdvance} <= 2'b11;
    @(posedge clk);
    {pcLoad, pcAdvance} <= 2'b00;
    repeat (3) @(posedge clk);
    pcAdvance <= 1'b1;
    #1;
    check(pc, 23'h001234);
    @(posedge clk);
    pcAdvance <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(pc, 23'h001236);
    // Reset in the middle of a visibility read must abandon it
    @(posedge clk);
    req <= {1'b1, 3'h0, 2'h0, 1'b0, 16'h8006, 73'h0};
    visibilityEnable <= 1'b1;
    @(posedge clk);
    req.valid <= 1'b0;
    @(posedge clk);
    sys_rst <= 1'b1;
    @(posedge clk);
    #1;
    check({ready, rsp.valid, progRd, xRdStrobe, pc}, {4'b1000, PC_RESET});
    @(posedge clk);
    sys_rst <= 1'b0;
    run(rows[0]);
    give_verdict();
  end
endmodule

bind pdsau_core pdsau_core_chk chk (.*);
